// file: hw/pcs_clock_defs.vh
// Register map, field positions, reset values and counts of the clock start-up control
`ifndef PCS_CLOCK_DEFS_VH
`define PCS_CLOCK_DEFS_VH

// Register byte offsets
`define PCS_REG_PLL_CS 4'h0
`define PCS_REG_SLEEP 4'h4
`define PCS_REG_CONV 4'h8
`define PCS_REG_STATUS 4'hC

// Control and status fields
`define PCS_BIT_IRQ_EN 0
`define PCS_BIT_IRQ_FLAG 1
`define PCS_BIT_LOCK 4
`define PCS_BIT_SW_EN 5
`define PCS_BIT_SLEEP_GO 8
`define PCS_BIT_CONV_SRC 0
`define PCS_BIT_RUN 8
`define PCS_BIT_PLL_ON 9
`define PCS_BIT_RATIO_OK 10

// Sleep modes
`define PCS_SM_ACTIVE 3'h0
`define PCS_SM_IDLE 3'h1
`define PCS_SM_ADC_QUIET 3'h2
`define PCS_SM_POWER_SAVE 3'h3
`define PCS_SM_POWER_DOWN 3'h4

// Reset values
`define PCS_RST_WORD 32'h0000_0000
`define PCS_RST_MODE 3'h0

// Dividers and start-up counts
`define PCS_PLL_MULT 8'h70
`define PCS_ADC_DIV 28
`define PCS_LOCK_DIV 2
`define PCS_WAKE_RC_CYCLES 16'h0002
`define PCS_WAKE_SYS_CYCLES 16'h0006
`define PCS_RESET_SYS_CYCLES 16'h000E
`define PCS_ULP_BASE_CYCLES 2048
`define PCS_ULP_TEST_CYCLES 16

`endif

// file: hw/pcs_tick_div.v
// Divide a stream of one-cycle ticks by a fixed ratio
`timescale 1ns/10ps
module pcs_tick_div #(
  parameter DIV = 2,
  parameter W = 5
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Tick stream
  input wire tickIn,
  input wire clear,
  output reg tickOut
);

  reg [W-1:0] count;

  // Count incoming ticks, emit one per DIV
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {W{1'b0}};
      tickOut <= 1'b0;
    end else if (clear) begin
      count <= {W{1'b0}};
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tickIn) begin
        if (count == DIV[W-1:0] - 1'b1) begin
          count <= {W{1'b0}};
          tickOut <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule // pcs_tick_div

// file: hw/pcs_clock_ctrl.v
// Clock distribution, PLL lock handling and start-up sequencing
`timescale 1ns/10ps
`include "pcs_clock_defs.vh"
module pcs_clock_ctrl #(
  parameter ULP_BASE = `PCS_ULP_BASE_CYCLES,
  parameter ULP_TEST = `PCS_ULP_TEST_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Avalon-MM slave
  input wire [3:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  output reg [31:0] avsReadData,
  output reg avsWaitRequest,
  // Oscillator levels, sampled on clk
  input wire pllClkIn,
  input wire slowRcIn,
  input wire ulpRcIn,
  input wire pllLock,
  // Fuse strap and wake sources
  input wire [1:0] startupTimeSelect,
  input wire wakeEvent,
  input wire extIrqAsync,
  input wire irqServiced,
  // Domain ticks and status
  output reg cpuTick,
  output reg ioTick,
  output reg flashTick,
  output reg adcTick,
  output reg wdtTick,
  output reg wutTick,
  output reg pllEnable,
  output reg cpuRun,
  output reg settleChangeIrq
);

  // Sequencer states
  localparam ST_RST_ULP = 3'd0;
  localparam ST_RST_SYS = 3'd1;
  localparam ST_RUN = 3'd2;
  localparam ST_SLEEP = 3'd3;
  localparam ST_WAKE_RC = 3'd4;
  localparam ST_WAKE_SYS = 3'd5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] count;
  reg [15:0] next_count;
  reg pllPrev;
  reg slowPrev;
  reg ulpPrev;
  reg lockReg;
  reg lockPrev;
  reg swEnable;
  reg settleChangeIrqEnable;
  reg settleChangeIrqFlag;
  reg converterSourceSelect;
  reg [2:0] sleepMode;
  reg [1:0] startupSel;
  reg strapTaken;
  reg [7:0] ratioCount;
  reg ratioOk;
  wire pllEdge;
  wire slowEdge;
  wire ulpEdge;
  wire halfTick;
  wire adcDivTick;
  wire sysTick;
  wire accept;
  wire wrPllCs;
  wire wrSleep;
  wire lockChange;
  wire wakeReq;
  wire deepSleep;
  reg [15:0] ulpTarget;
  reg [31:0] readWord;

  // Rising edges of the sampled oscillator levels
  assign pllEdge = pllClkIn & ~pllPrev;
  assign slowEdge = slowRcIn & ~slowPrev;
  assign ulpEdge = ulpRcIn & ~ulpPrev;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pllPrev <= 1'b0;
      slowPrev <= 1'b0;
      ulpPrev <= 1'b0;
      lockReg <= 1'b0;
      lockPrev <= 1'b0;
    end else begin
      pllPrev <= pllClkIn;
      slowPrev <= slowRcIn;
      ulpPrev <= ulpRcIn;
      lockReg <= pllLock;
      lockPrev <= lockReg;
    end
  end

  // Halved PLL clock used until lock
  pcs_tick_div #(
    .DIV(`PCS_LOCK_DIV),
    .W(2)
  ) uHalf (
    .clk(clk),
    .arst_n(arst_n),
    .tickIn(pllEdge),
    .clear(1'b0),
    .tickOut(halfTick)
  );

  // Fixed converter prescaler off the PLL
  pcs_tick_div #(
    .DIV(`PCS_ADC_DIV),
    .W(5)
  ) uAdcDiv (
    .clk(clk),
    .arst_n(arst_n),
    .tickIn(pllEdge),
    .clear(1'b0),
    .tickOut(adcDivTick)
  );

  // Halved rate is a registered tick, so the full rate is delayed to match
  reg pllEdgeDly;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pllEdgeDly <= 1'b0;
    end else begin
      pllEdgeDly <= pllEdge;
    end
  end
  assign sysTick = lockReg ? pllEdgeDly : halfTick;

  // Reference ratio check: PLL edges per slow RC period
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ratioCount <= 8'h00;
      ratioOk <= 1'b0;
    end else if (slowEdge) begin
      ratioCount <= {7'h00, pllEdge}; // Edge in this cycle opens the new window
      ratioOk <= (ratioCount == `PCS_PLL_MULT);
    end else if (pllEdge && ratioCount != 8'hFF) begin
      ratioCount <= ratioCount + 8'h01;
    end
  end

  // Strap captured once after reset release, held afterwards
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startupSel <= 2'b00;
      strapTaken <= 1'b0;
    end else if (!strapTaken) begin
      startupSel <= startupTimeSelect;
      strapTaken <= 1'b1;
    end
  end

  // Real-time reset delay in ULP cycles; 00 is a short test setting
  always @* begin
    case (startupSel)
      2'b01: ulpTarget = ULP_BASE[15:0];
      2'b10: ulpTarget = {ULP_BASE[14:0], 1'b0};
      2'b11: ulpTarget = {ULP_BASE[13:0], 2'b00};
      default: ulpTarget = ULP_TEST[15:0];
    endcase
  end

  assign deepSleep = (sleepMode == `PCS_SM_POWER_SAVE) || (sleepMode == `PCS_SM_POWER_DOWN);
  // Async interrupt inputs are watched on clk, not on the gated I/O tick
  assign wakeReq = wakeEvent | extIrqAsync;

  // Bus handshake: one wait cycle, then the access completes
  assign accept = (avsRead | avsWrite) & ~avsWaitRequest;
  assign wrPllCs = accept & avsWrite & (avsAddress == `PCS_REG_PLL_CS);
  assign wrSleep = accept & avsWrite & (avsAddress == `PCS_REG_SLEEP);

  // Start-up sequencer
  always @* begin
    next_state = state;
    next_count = count;
    case (state)
      ST_RST_ULP: begin
        if (strapTaken && ulpEdge) begin
          if (count + 16'h0001 >= ulpTarget) begin
            next_state = ST_RST_SYS;
            next_count = 16'h0000;
          end else begin
            next_count = count + 16'h0001;
          end
        end
      end
      ST_RST_SYS: begin
        if (sysTick) begin
          if (count + 16'h0001 >= `PCS_RESET_SYS_CYCLES) begin
            next_state = ST_RUN;
            next_count = 16'h0000;
          end else begin
            next_count = count + 16'h0001;
          end
        end
      end
      ST_RUN: begin
        if (wrSleep && avsWriteData[`PCS_BIT_SLEEP_GO]
            && avsWriteData[2:0] != `PCS_SM_ACTIVE) begin
          next_state = ST_SLEEP;
          next_count = 16'h0000;
        end
      end
      ST_SLEEP: begin
        if (wakeReq) begin
          next_count = 16'h0000;
          if (!deepSleep) begin
            next_state = ST_RUN;
          end else if (pllEnable) begin
            next_state = ST_WAKE_SYS;
          end else begin
            next_state = ST_WAKE_RC;
          end
        end
      end
      ST_WAKE_RC: begin
        if (slowEdge) begin
          if (count + 16'h0001 >= `PCS_WAKE_RC_CYCLES) begin
            next_state = ST_WAKE_SYS;
            next_count = 16'h0000;
          end else begin
            next_count = count + 16'h0001;
          end
        end
      end
      ST_WAKE_SYS: begin
        // Counted on the core clock source, PLL lock not awaited
        if (sysTick) begin
          if (count + 16'h0001 >= `PCS_WAKE_SYS_CYCLES) begin
            next_state = ST_RUN;
            next_count = 16'h0000;
          end else begin
            next_count = count + 16'h0001;
          end
        end
      end
      default: begin
        next_state = ST_RST_ULP;
        next_count = 16'h0000;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RST_ULP;
      count <= 16'h0000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Software controls and the lock-change flag
  assign lockChange = lockReg ^ lockPrev;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      swEnable <= 1'b0;
      settleChangeIrqEnable <= 1'b0;
      settleChangeIrqFlag <= 1'b0;
      converterSourceSelect <= 1'b0;
      sleepMode <= `PCS_RST_MODE;
    end else begin
      if (wrPllCs) begin
        swEnable <= avsWriteData[`PCS_BIT_SW_EN];
        settleChangeIrqEnable <= avsWriteData[`PCS_BIT_IRQ_EN];
      end
      // A lock edge in the clearing cycle keeps the flag set
      if (lockChange) begin
        settleChangeIrqFlag <= 1'b1;
      end else if ((wrPllCs && avsWriteData[`PCS_BIT_IRQ_FLAG]) || irqServiced) begin
        settleChangeIrqFlag <= 1'b0;
      end
      if (wrSleep) begin
        sleepMode <= avsWriteData[2:0];
      end
      if (accept && avsWrite && avsAddress == `PCS_REG_CONV) begin
        converterSourceSelect <= avsWriteData[`PCS_BIT_CONV_SRC];
      end
    end
  end

  // Domain clock ticks gated by sequencer state and sleep mode; watchdog and wake timer ticks run ungated
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpuTick <= 1'b0;
      ioTick <= 1'b0;
      flashTick <= 1'b0;
      adcTick <= 1'b0;
      wdtTick <= 1'b0;
      wutTick <= 1'b0;
      pllEnable <= 1'b1;
      cpuRun <= 1'b0;
      settleChangeIrq <= 1'b0;
    end else begin
      cpuTick <= sysTick && state == ST_RUN;
      flashTick <= sysTick && state == ST_RUN;
      ioTick <= sysTick && (state == ST_RUN
                || (state == ST_SLEEP && sleepMode == `PCS_SM_IDLE));
      // Converter source: PLL/28 by default, slow RC when selected
      adcTick <= (converterSourceSelect ? slowEdge : adcDivTick)
                 && (state == ST_RUN || (state == ST_SLEEP && !deepSleep));
      wdtTick <= ulpEdge;
      wutTick <= ulpEdge;
      // PLL off in deep sleep and during the extra slow RC wait, unless swEnable holds it on
      pllEnable <= swEnable || !((next_state == ST_SLEEP && deepSleep)
                   || next_state == ST_WAKE_RC);
      cpuRun <= next_state == ST_RUN;
      settleChangeIrq <= settleChangeIrqFlag && settleChangeIrqEnable;
    end
  end

  // Read mux; unmapped addresses read as zero
  always @* begin
    readWord = `PCS_RST_WORD;
    case (avsAddress)
      `PCS_REG_PLL_CS: begin
        readWord[`PCS_BIT_SW_EN] = swEnable;
        readWord[`PCS_BIT_LOCK] = lockReg;
        readWord[`PCS_BIT_IRQ_FLAG] = settleChangeIrqFlag;
        readWord[`PCS_BIT_IRQ_EN] = settleChangeIrqEnable;
      end
      `PCS_REG_SLEEP: readWord[2:0] = sleepMode;
      `PCS_REG_CONV: readWord[`PCS_BIT_CONV_SRC] = converterSourceSelect;
      `PCS_REG_STATUS: begin
        readWord[1:0] = startupSel;
        readWord[4:2] = state;
        readWord[`PCS_BIT_RUN] = cpuRun;
        readWord[`PCS_BIT_PLL_ON] = pllEnable;
        readWord[`PCS_BIT_RATIO_OK] = ratioOk;
      end
      default: readWord = `PCS_RST_WORD;
    endcase
  end

  // Waitrequest drops for one cycle per request
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avsWaitRequest <= 1'b1;
      avsReadData <= `PCS_RST_WORD;
    end else begin
      if ((avsRead || avsWrite) && avsWaitRequest) begin
        avsWaitRequest <= 1'b0;
        avsReadData <= avsRead ? readWord : `PCS_RST_WORD;
      end else begin
        avsWaitRequest <= 1'b1;
      end
    end
  end

endmodule // pcs_clock_ctrl

// file: test/pcs_clock_ctrl_properties.sv
// Concurrent checks on the clock start-up control ports
`timescale 1ns/10ps
module pcs_clock_ctrl_props (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Bus handshake
  input wire avsRead,
  input wire avsWrite,
  input wire avsWaitRequest,
  // Oscillator levels
  input wire pllClkIn,
  input wire ulpRcIn,
  input wire pllLock,
  // Domain ticks
  input wire cpuTick,
  input wire ioTick,
  input wire flashTick,
  input wire wdtTick,
  input wire wutTick,
  input wire cpuRun
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Locked PLL edge while the core runs
  sequence lockedRise;
    pllLock [*4] ##0 ($rose(pllClkIn) && cpuRun);
  endsequence
  // Core tick after a long unlocked stretch
  sequence unlockedTick;
    !pllLock [*6] ##0 cpuTick;
  endsequence
  a_full_rate: assert property (lockedRise |-> ##[2:3] (cpuTick || !cpuRun))
    else $error("core tick missing at full rate");
  a_half_rate: assert property (unlockedTick |-> !$past(cpuTick, 2))
    else $error("core tick too fast while unlocked");
  a_wdt_follows_ulp: assert property ($rose(ulpRcIn) |-> ##[1:3] wdtTick)
    else $error("watchdog tick missing");
  a_wut_with_wdt: assert property (wutTick == wdtTick)
    else $error("wake timer tick differs from watchdog");
  a_flash_with_core: assert property (cpuTick |-> flashTick)
    else $error("flash tick missing");
  a_io_with_core: assert property (cpuTick |-> ioTick)
    else $error("io tick missing");
  a_tick_single: assert property (cpuTick |=> !cpuTick)
    else $error("core tick wider than one cycle");
  a_request_answer: assert property ($rose(avsRead || avsWrite) |=> !avsWaitRequest)
    else $error("bus answer late");
  a_wait_one_cycle: assert property ((avsRead || avsWrite) && !avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low too long");
endmodule // pcs_clock_ctrl_props

bind pcs_clock_ctrl pcs_clock_ctrl_props u_pcs_clock_ctrl_props (.clk(clk), .arst_n(arst_n),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest),
  .pllClkIn(pllClkIn), .ulpRcIn(ulpRcIn), .pllLock(pllLock), .cpuTick(cpuTick),
  .ioTick(ioTick), .flashTick(flashTick), .wdtTick(wdtTick), .wutTick(wutTick),
  .cpuRun(cpuRun));

// file: test/pcs_osc_model.sv
// Oscillator and PLL stand-in driving the level inputs
`timescale 1ns/10ps
module pcs_osc_model #(
  parameter LOCK_CYC = 64
) (
  // Clock
  input wire clk,
  // Control
  input wire pllEnable,
  input wire lockDrop,
  // Oscillator levels
  output reg pllClkIn = 1'b0,
  output reg slowRcIn = 1'b0,
  output reg ulpRcIn = 1'b0,
  output reg pllLock = 1'b0
);
  reg [7:0] rcCnt = 8'h00;
  reg [2:0] ulpCnt = 3'h0;
  reg [7:0] lockCnt = 8'h00;
  // An unknown enable before reset counts as off, so no unknown circulates
  wire pllOn = (pllEnable === 1'b1);
  // PLL period two clk, so 224 clk per slow RC period; stands still when off
  always @(posedge clk) begin
    rcCnt <= (rcCnt == 8'hdf) ? 8'h00 : rcCnt + 8'h01;
    slowRcIn <= (rcCnt < 8'h70);
    ulpCnt <= ulpCnt + 3'h1;
    ulpRcIn <= ulpCnt[2]; // Free running
    pllClkIn <= pllOn & ~pllClkIn;
    lockCnt <= !pllOn ? 8'h00 : (lockCnt < LOCK_CYC) ? lockCnt + 8'h01 : lockCnt;
    pllLock <= pllOn && (lockDrop !== 1'b1) && (lockCnt >= LOCK_CYC);
  end
endmodule // pcs_osc_model

// file: test/test_pcs_clock_ctrl.sv
// Self-checking bench of the clock start-up control
`timescale 1ns/10ps
`include "pcs_clock_defs.vh"
module test_pcs_clock_ctrl;
  reg clk, arst_n, avsRead, avsWrite, wakeEvent, extIrqAsync, irqServiced, lockDrop;
  reg [3:0] avsAddress;
  reg [31:0] avsWriteData, rd;
  reg [1:0] strap;
  wire [31:0] avsReadData;
  wire avsWaitRequest, pllClkIn, slowRcIn, ulpRcIn, pllLock, cpuTick, ioTick, flashTick;
  wire adcTick, wdtTick, wutTick, pllEnable, cpuRun, settleChangeIrq;
  integer nFail, nChecks, cyc, cCpu, cWdt, cAdc, cIo, i;
  // Short ULP counts keep reset waits brief
  pcs_clock_ctrl #(.ULP_BASE(8), .ULP_TEST(4)) u_pcs_clock_ctrl (.clk(clk), .arst_n(arst_n),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .pllClkIn(pllClkIn), .slowRcIn(slowRcIn), .ulpRcIn(ulpRcIn), .pllLock(pllLock),
    .startupTimeSelect(strap), .wakeEvent(wakeEvent), .extIrqAsync(extIrqAsync),
    .irqServiced(irqServiced), .cpuTick(cpuTick), .ioTick(ioTick), .flashTick(flashTick),
    .adcTick(adcTick), .wdtTick(wdtTick), .wutTick(wutTick), .pllEnable(pllEnable),
    .cpuRun(cpuRun), .settleChangeIrq(settleChangeIrq));
  pcs_osc_model u_pcs_osc_model (.clk(clk), .pllEnable(pllEnable), .lockDrop(lockDrop),
    .pllClkIn(pllClkIn), .slowRcIn(slowRcIn), .ulpRcIn(ulpRcIn), .pllLock(pllLock));
  // Clock of 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task completeRun;
    begin
      $display("checks %0d errors %0d", nChecks, nFail);
      if (nFail == 0 && nChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // Range compare; an unknown never passes
  task chk(input [31:0] got, input [31:0] lo, input [31:0] hi);
    begin
      nChecks = nChecks + 1;
      if ((got >= lo && got <= hi) !== 1'b1) begin
        nFail = nFail + 1;
        $display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
      end
    end
  endtask
  // Bus cycles held until waitrequest is sampled low
  task busWr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= 1'b1;
      do @(posedge clk); while (avsWaitRequest !== 1'b0);
      avsWrite <= 1'b0;
    end
  endtask
  task busRd(input [3:0] a);
    begin
      @(posedge clk);
      avsAddress <= a;
      avsRead <= 1'b1;
      do @(posedge clk); while (avsWaitRequest !== 1'b0);
      rd = avsReadData;
      avsRead <= 1'b0;
    end
  endtask
  task waitRun;
    begin
      cyc = 0;
      while (cpuRun !== 1'b1) begin
        @(posedge clk);
        cyc = cyc + 1;
      end
    end
  endtask
  // Count domain ticks over a span
  task tally(input integer len);
    begin
      cCpu = 0;
      cWdt = 0;
      cAdc = 0;
      cIo = 0;
      repeat (len) begin
        @(posedge clk);
        cCpu = cCpu + cpuTick;
        cIo = cIo + ioTick;
        cWdt = cWdt + wdtTick;
        cAdc = cAdc + adcTick;
      end
    end
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    nFail = nFail + 1;
    completeRun;
  end
  // Main sequence
  initial begin
    {arst_n, avsRead, avsWrite, wakeEvent, extIrqAsync, irqServiced, lockDrop} = 7'h00;
    avsAddress = 4'h0;
    avsWriteData = 32'h0000_0000;
    strap = 2'h1;
    nFail = 0;
    nChecks = 0;
    for (i = 1; i < 4; i = i + 1) begin
      arst_n <= 1'b0;
      strap <= i[1:0]; // Setting 00 left unused
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      waitRun;
      chk(cyc, (32 << i) + 8, (32 << i) + 80);
    end
    strap <= 2'h0;
    repeat (500) @(posedge clk);
    busRd(`PCS_REG_STATUS);
    chk(rd[1:0], 3, 3);
    chk(rd[10:8], 7, 7);
    busRd(`PCS_REG_PLL_CS);
    chk(rd[5:0], 32'h0000_0012, 32'h0000_0012);
    busRd(4'h1);
    chk(rd, 0, 0);
    // Lock loss and regain, cleared by write and by service
    busWr(`PCS_REG_PLL_CS, 32'h0000_0003);
    lockDrop <= 1'b1;
    repeat (6) @(posedge clk);
    chk(settleChangeIrq, 1, 1);
    busRd(`PCS_REG_PLL_CS);
    chk(rd[5:0], 3, 3);
    busWr(`PCS_REG_PLL_CS, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk(settleChangeIrq, 0, 0);
    lockDrop <= 1'b0;
    repeat (6) @(posedge clk);
    chk(settleChangeIrq, 1, 1);
    irqServiced <= 1'b1;
    @(posedge clk);
    irqServiced <= 1'b0;
    repeat (3) @(posedge clk);
    chk(settleChangeIrq, 0, 0);
    busWr(`PCS_REG_PLL_CS, 32'h0000_0000);
    lockDrop <= 1'b1;
    repeat (6) @(posedge clk);
    chk(settleChangeIrq, 0, 0);
    busRd(`PCS_REG_PLL_CS);
    chk(rd[1], 1, 1);
    lockDrop <= 1'b0;
    while (pllLock !== 1'b1) @(posedge clk);
    // Converter clock from both sources
    busWr(`PCS_REG_CONV, 32'h0000_0000);
    tally(448);
    chk(cAdc, 7, 9);
    chk(cWdt, 55, 57);
    busWr(`PCS_REG_CONV, 32'h0000_0001);
    busRd(`PCS_REG_CONV);
    chk(rd[0], 1, 1);
    tally(448);
    chk(cAdc, 1, 3);
    // Power-down with the PLL off, woken by a wake event
    busWr(`PCS_REG_SLEEP, 32'h0000_0104);
    repeat (2) @(posedge clk); // Last core tick before sleep may still stand
    tally(300);
    chk(cCpu, 0, 0);
    chk(cWdt, 36, 39);
    chk(pllEnable, 0, 0);
    wakeEvent <= 1'b1;
    cyc = 0;
    while (pllEnable !== 1'b1) begin
      @(posedge clk);
      cyc = cyc + 1;
    end
    chk(cyc, 200, 460);
    waitRun;
    chk(cyc, 10, 40);
    chk(pllLock, 0, 0);
    wakeEvent <= 1'b0;
    // Power-save with the PLL kept on, woken by the external line
    busWr(`PCS_REG_PLL_CS, 32'h0000_0020);
    repeat (80) @(posedge clk);
    busWr(`PCS_REG_SLEEP, 32'h0000_0103);
    repeat (50) @(posedge clk);
    chk(pllEnable, 1, 1);
    extIrqAsync <= 1'b1;
    waitRun;
    chk(cyc, 8, 40);
    extIrqAsync <= 1'b0;
    // Idle keeps I/O and converter domains running, core stopped
    busWr(`PCS_REG_SLEEP, 32'h0000_0101);
    repeat (2) @(posedge clk);
    tally(224);
    chk(cCpu, 0, 0);
    chk(cIo, 111, 112);
    chk(cAdc, 1, 1);
    wakeEvent <= 1'b1;
    waitRun;
    wakeEvent <= 1'b0;
    // Converter-quiet mode stops I/O but not the converter domain
    busWr(`PCS_REG_SLEEP, 32'h0000_0102);
    repeat (2) @(posedge clk);
    tally(224);
    chk(cIo, 0, 0);
    chk(cAdc, 1, 1);
    wakeEvent <= 1'b1;
    waitRun;
    wakeEvent <= 1'b0;
    completeRun;
  end
endmodule // test_pcs_clock_ctrl
